// File: adcs_consts.vh
// Constants for the round-robin converter supervisor.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH
`define ADCS_NUM_CH        13
`define ADCS_NUM_SUPPLY    10
`define ADCS_CH_W          4
`define ADCS_CODE_W        12
`define ADCS_CODE_FULL     12'hfff
`define ADCS_CODE_ZERO     12'h000
`define ADCS_TEMP_M128     12'h400
`define ADCS_TEMP_ZERO     12'h800
`define ADCS_TEMP_P128     12'hc00
`define ADCS_AVG_PASSES    16
`define ADCS_ACC_W         16
`define ADCS_AVG_SHIFT     4
`define ADCS_CLK_HZ        10000000
`define ADCS_CONV_US       500
`define ADCS_REMOTE_MS     600
`define ADCS_REMOTE_CYCLES 16
`define ADCS_ST_IDLE       2'h0
`define ADCS_ST_SCAN       2'h1
`define ADCS_ST_CONV       2'h2
`define ADCS_ST_WRITE      2'h3
`endif

// File: adcs_result_mem.v
// Result and accumulator store, one word per channel.
// Assumes single clock, no reset, registered read.
`timescale 1ns/100ps
`include "adcs_consts.vh"
module adcs_result_mem #(
    parameter DW = 16,
    parameter AW = 4,
    parameter DEPTH = 13
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:DEPTH-1];

    // Write port and registered read port
    always @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// File: adcs_supervisor.v
// Round-robin converter sequencer with averaging and limit warnings.
// Assumes a 10 MHz clock, synchronous converter codes and a front end
// that samples the channel on adc_mux_sel when adc_start pulses.
`timescale 1ns/100ps
`include "adcs_consts.vh"
module adcs_supervisor #(
    parameter NCH       = `ADCS_NUM_CH,
    parameter CONV_CYC  = (`ADCS_CLK_HZ / 1000000) * `ADCS_CONV_US,
    parameter REM_CYC   = (`ADCS_CLK_HZ / 1000) * `ADCS_REMOTE_MS,
    parameter BIAS_CYC  = REM_CYC / (2 * `ADCS_REMOTE_CYCLES)
) (
    input  wire                    clk,
    input  wire                    rst_n,
    input  wire [NCH-1:0]          chan_select,
    input  wire                    continuous_mode,
    input  wire                    averaging_enable,
    input  wire                    host_start,
    input  wire                    sequencing_engine_start,
    input  wire                    host_stop,
    input  wire [NCH*12-1:0]       limit_values,
    input  wire [NCH-1:0]          limit_is_max,
    input  wire [11:0]             adc_code,
    input  wire                    adc_done,
    input  wire [3:0]              read_chan,
    output reg  [3:0]              adc_mux_sel,
    output reg                     adc_start,
    output reg                     remote_bias_high,
    output reg                     busy,
    output reg                     results_updated,
    output reg  [15:0]             read_data,
    output reg  [NCH-1:0]          limit_warning_status,
    output reg  [NCH-1:0]          sequencing_engine_warning
);
    localparam CW = 24;
    localparam [3:0] REM_FIRST = 4'd11; // Channels 11 and 12 are remote diodes
    localparam [CW-1:0] CONV_LAST = CONV_CYC - 1; // Last timer count of a supply slot
    localparam [CW-1:0] REM_LAST  = REM_CYC - 1;  // Last timer count of a remote slot

    reg [1:0]    st_q;
    reg [3:0]    ch_q;
    reg [4:0]    pass_q;
    reg [CW-1:0] tmr_q;
    reg [CW-1:0] btmr_q;
    reg          got_q;
    wire [CW-1:0] slot_last;
    reg [NCH-1:0] sel_q;
    reg          avg_q;
    reg          cont_q;
    wire         mem_we;
    wire [3:0]   mem_waddr;
    wire [15:0]  mem_wdata;
    wire [3:0]   mem_raddr;
    wire [15:0]  mem_rdata;
    reg  [15:0]  acc_word;
    reg  [15:0]  res_word;
    reg  [11:0]  lim;
    reg          over;
    reg          remote_ch;

    // Accumulator store; published results are kept in out_q
    adcs_result_mem #(.DW(16), .AW(4), .DEPTH(NCH)) u_acc (
        .clk   (clk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // Accumulator read of the channel under conversion
    assign mem_raddr = ch_q;
    assign mem_we    = (st_q == `ADCS_ST_CONV) && adc_done;
    assign mem_waddr = ch_q;
    assign mem_wdata = acc_word;
    // Slot length depends on whether a remote diode is converting
    assign slot_last = remote_ch ? REM_LAST : CONV_LAST;

    // Next accumulator value; first pass replaces, later passes add
    always @*
    begin
        if (!avg_q || pass_q == 5'd0)
            acc_word = {4'h0, adc_code};
        else
            acc_word = mem_rdata + {4'h0, adc_code};
        res_word = avg_q ? (acc_word >> `ADCS_AVG_SHIFT) : acc_word;
        lim = limit_values[ch_q*`ADCS_CODE_W +: `ADCS_CODE_W];
        remote_ch = (ch_q >= REM_FIRST);
        // Over-limit for max, under-limit for min
        over = limit_is_max[ch_q] ? (res_word[11:0] > lim) : (res_word[11:0] < lim);
    end

    // Sequencer state machine
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_q <= `ADCS_ST_IDLE;
            ch_q <= 4'h0;
            pass_q <= 5'd0;
            tmr_q <= {CW{1'b0}};
            got_q <= 1'b0;
            sel_q <= {NCH{1'b0}};
            avg_q <= 1'b0;
            cont_q <= 1'b0;
            adc_start <= 1'b0;
            busy <= 1'b0;
            results_updated <= 1'b0;
            adc_mux_sel <= 4'h0;
            limit_warning_status <= {NCH{1'b0}};
            sequencing_engine_warning <= {NCH{1'b0}};
        end
        else
        begin
            adc_start <= 1'b0;
            results_updated <= 1'b0;
            case (st_q)
                `ADCS_ST_IDLE:
                begin
                    busy <= 1'b0;
                    if ((host_start || sequencing_engine_start) && |chan_select)
                    begin
                        sel_q <= chan_select;
                        avg_q <= averaging_enable;
                        cont_q <= continuous_mode;
                        ch_q <= 4'h0;
                        pass_q <= 5'd0;
                        busy <= 1'b1;
                        st_q <= `ADCS_ST_SCAN;
                    end
                end
                `ADCS_ST_SCAN:
                begin
                    if (host_stop)
                        st_q <= `ADCS_ST_IDLE;
                    else if (ch_q >= NCH)
                        st_q <= `ADCS_ST_WRITE;
                    else if (sel_q[ch_q])
                    begin
                        adc_mux_sel <= ch_q;
                        adc_start <= 1'b1;
                        tmr_q <= {CW{1'b0}};
                        st_q <= `ADCS_ST_CONV;
                    end
                    else
                        ch_q <= ch_q + 4'h1;
                end
                `ADCS_ST_CONV:
                begin
                    // Hold each channel for its full slot, however early the code arrives
                    if (tmr_q < slot_last)
                        tmr_q <= tmr_q + 1'b1;
                    if (adc_done)
                    begin
                        got_q <= 1'b1;
                        if (!avg_q || pass_q == (`ADCS_AVG_PASSES - 1))
                        begin
                            // Compare against the fresh result of this channel
                            limit_warning_status[ch_q] <= over;
                            sequencing_engine_warning[ch_q] <= over;
                        end
                    end
                    // Move on only once the code is in and the slot has run out
                    if ((got_q || adc_done) && tmr_q >= slot_last)
                    begin
                        got_q <= 1'b0;
                        ch_q <= ch_q + 4'h1;
                        st_q <= `ADCS_ST_SCAN;
                    end
                end
                `ADCS_ST_WRITE:
                begin
                    ch_q <= 4'h0;
                    if (avg_q && pass_q != (`ADCS_AVG_PASSES - 1))
                    begin
                        pass_q <= pass_q + 5'd1;
                        st_q <= `ADCS_ST_SCAN;
                    end
                    else
                    begin
                        results_updated <= 1'b1;
                        pass_q <= 5'd0;
                        st_q <= cont_q ? `ADCS_ST_SCAN : `ADCS_ST_IDLE;
                    end
                end
                default:
                    st_q <= `ADCS_ST_IDLE;
            endcase
        end
    end

    // Output register file: capture final result per channel
    reg [15:0] out_q [0:NCH-1];
    integer i;
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < NCH; i = i + 1)
                out_q[i] <= 16'h0000;
            read_data <= 16'h0000;
        end
        else
        begin
            if (mem_we && (!avg_q || pass_q == (`ADCS_AVG_PASSES - 1)))
                out_q[ch_q] <= {4'h0, res_word[11:0]};
            read_data <= (read_chan < NCH) ? out_q[read_chan] : 16'h0000;
        end
    end

    // Remote diode bias toggles between I and N*I during conversion
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            btmr_q <= {CW{1'b0}};
            remote_bias_high <= 1'b0;
        end
        else if (st_q == `ADCS_ST_CONV && remote_ch)
        begin
            if (btmr_q >= BIAS_CYC - 1)
            begin
                btmr_q <= {CW{1'b0}};
                remote_bias_high <= ~remote_bias_high;
            end
            else
                btmr_q <= btmr_q + 1'b1;
        end
        else
        begin
            btmr_q <= {CW{1'b0}};
            remote_bias_high <= 1'b0;
        end
    end
endmodule

// File: adcs_supervisor_sva.sv
// Port checker for the converter supervisor.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module adcs_supervisor_sva #(
    parameter NCH      = 13,
    parameter CONV_CYC = 5000
) (
    input wire           clk,
    input wire           rst_n,
    input wire [NCH-1:0] chan_select,
    input wire           host_start,
    input wire           sequencing_engine_start,
    input wire [3:0]     read_chan,
    input wire [3:0]     adc_mux_sel,
    input wire           adc_start,
    input wire           busy,
    input wire           remote_bias_high,
    input wire           results_updated,
    input wire [15:0]    read_data,
    input wire [NCH-1:0] limit_warning_status,
    input wire [NCH-1:0] sequencing_engine_warning
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles since the last conversion start, saturating at one slot
    int unsigned gap_q;
    always @(posedge clk)
    begin
        if (!rst_n)
            gap_q <= CONV_CYC;
        else if (adc_start)
            gap_q <= 1;
        else if (gap_q < CONV_CYC)
            gap_q <= gap_q + 1;
    end
    // Run request and single conversion pulse
    sequence s_kick;
        !busy && (host_start || sequencing_engine_start) && (|chan_select);
    endsequence
    sequence s_conv;
        adc_start ##1 !adc_start;
    endsequence
    a_start_taken: assert property (s_kick |=> busy) else $error("start lost");
    a_empty_refused: assert property (!busy && chan_select == 0 |=> !busy) else $error("empty run");
    a_conv_pulse: assert property (adc_start |-> s_conv) else $error("long start");
    a_mux_range: assert property (adc_start |-> adc_mux_sel < 4'hd) else $error("bad channel");
    a_mux_selected: assert property (adc_start |-> busy && chan_select[adc_mux_sel]) else $error("unselected");
    a_first_conv: assert property ($rose(busy) |-> ##[1:16] adc_start) else $error("no conversion");
    a_upd_pulse: assert property (results_updated |=> !results_updated) else $error("long update");
    a_warn_copy: assert property (sequencing_engine_warning == limit_warning_status) else $error("copy");
    a_read_blank: assert property (read_chan > 4'hc |=> read_data == 16'h0) else $error("blank read");
    a_conv_paced: assert property (adc_start |-> gap_q >= CONV_CYC) else $error("short slot");
    a_bias_remote: assert property (remote_bias_high |-> busy && adc_mux_sel >= 4'hb) else $error("bias");
endmodule
bind adcs_supervisor adcs_supervisor_sva #(.NCH(NCH), .CONV_CYC(CONV_CYC)) i_adcs_supervisor_sva (.clk(clk),
    .rst_n(rst_n), .chan_select(chan_select), .host_start(host_start),
    .sequencing_engine_start(sequencing_engine_start), .remote_bias_high(remote_bias_high),
    .read_chan(read_chan), .adc_mux_sel(adc_mux_sel), .adc_start(adc_start), .busy(busy),
    .results_updated(results_updated), .read_data(read_data), .limit_warning_status(limit_warning_status),
    .sequencing_engine_warning(sequencing_engine_warning));

// File: adcs_front_model.sv
// Converter front end model: code per channel after a delay.
// Assumes start pulses carry the channel on the mux select.
`timescale 1ns/100ps
module adcs_front_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        adc_start,
    input  wire logic        slow,
    input  wire logic [3:0]  adc_mux_sel,
    input  wire logic [11:0] base,
    output logic      [11:0] adc_code = 12'h0,
    output logic             adc_done = 1'b0
);
    int         cnt;
    logic [3:0] ch;
    // Code toggles when not valid; done is one cycle
    always @(posedge clk)
    begin
        adc_done <= 1'b0;
        adc_code <= ~adc_code;
        if (!rst_n)
            cnt <= 0;
        else if (adc_start)
        begin
            cnt <= slow ? 7 : 1;
            ch <= adc_mux_sel;
        end
        else if (cnt == 1)
        begin
            adc_done <= 1'b1;
            adc_code <= base + 12'(ch);
            cnt <= 0;
        end
        else if (cnt > 1)
            cnt <= cnt - 1;
    end
endmodule

// File: adcs_supervisor_bench.sv
// Self-checking bench for the converter supervisor.
// Assumes the model and checker compile first.
`timescale 1ns/100ps
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin errors++; $display("Error %0t %h %h",$time,a,b); end end
module adcs_supervisor_bench;
    logic clk=0, rst_n=0, cont=0, avg=0, hs=0, ses=0, stop=0, slow=0, st, upd, busy, done, rd_v=0, rd_d=0;
    logic [12:0]  sel=0, ismax=0, warn;
    logic [155:0] lims=0;
    logic [11:0]  code, base=0, er[13]='{default:0};
    logic [3:0]   rch=0, msel;
    logic [15:0]  rdata;
    logic [20:0]  e, q[$];
    logic         ew[13]='{default:0};
    int           errors=0, cmp_count=0, nst=0, n0;
    always #50 clk = ~clk;
    adcs_supervisor #(.CONV_CYC(10), .REM_CYC(40), .BIAS_CYC(2)) i_adcs_supervisor (.clk(clk), .rst_n(rst_n),
        .chan_select(sel), .continuous_mode(cont), .averaging_enable(avg), .host_start(hs),
        .sequencing_engine_start(ses), .host_stop(stop), .limit_values(lims), .limit_is_max(ismax),
        .adc_code(code), .adc_done(done), .read_chan(rch), .adc_mux_sel(msel), .adc_start(st),
        .remote_bias_high(), .busy(busy), .results_updated(upd), .read_data(rdata),
        .limit_warning_status(warn), .sequencing_engine_warning());
    adcs_front_model i_adcs_front_model (.clk(clk), .rst_n(rst_n), .adc_start(st), .slow(slow),
        .adc_mux_sel(msel), .base(base), .adc_code(code), .adc_done(done));
    // Compare each read with the oldest note; count conversions
    always @(posedge clk)
    begin
        rd_d <= rd_v;
        nst <= nst + st;
        if (rd_d)
        begin
            e = q.pop_front();
            `CHK(rdata, e[15:0])
            if (e[20:17] < 4'hd) `CHK(warn[e[20:17]], e[16])
        end
    end
    task end_sim;
        $display("Compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wait_upd;
        for (int i = 0; i < 40000 && upd !== 1'b1; i++) @(posedge clk);
        `CHK(upd, 1'b1)
        @(posedge clk);
    endtask
    task wait_idle;
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
        `CHK(busy, 1'b0)
    endtask
    task rd(input int ch);
        @(posedge clk);
        rch <= 4'(ch);
        rd_v <= 1'b1;
        q.push_back(ch < 13 ? {4'(ch), ew[ch], 4'h0, er[ch]} : {4'(ch), 17'h0});
        @(posedge clk);
        rd_v <= 1'b0;
    endtask
    task go(input bit se);
        @(posedge clk);
        hs <= !se;
        ses <= se;
        @(posedge clk);
        hs <= 1'b0;
        ses <= 1'b0;
    endtask
    // Main sequence: refused start, then four runs
    initial
    begin
        void'($urandom(89));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK({busy, st, upd, warn}, 16'h0)
        go(1'b0);
        repeat (3) @(posedge clk);
        `CHK(busy, 1'b0)
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            sel <= (k == 0) ? 13'h1fff : 13'($urandom) | 13'h400;
            ismax <= 13'($urandom);
            base <= 12'h400 + 12'($urandom & 32'h7ff);
            for (int c = 0; c < 13; c++) lims[12*c +: 12] <= 12'($urandom);
            avg <= (k == 2);
            cont <= (k == 3);
            slow <= k[0];
            n0 = nst;
            go(k[0]);
            wait_upd();
            if (k == 3) begin wait_upd(); stop <= 1'b1; end
            wait_idle();
            stop <= 1'b0;
            if (k == 2) `CHK(nst - n0, 16 * $countones(sel))
            for (int c = 0; c < 13; c++) if (sel[c]) begin er[c] = base + 12'(c); ew[c] = ismax[c] ? er[c] > lims[12*c +: 12] : er[c] < lims[12*c +: 12]; end
            for (int c = 0; c < 15; c++) rd(c);
        end
        end_sim();
    end
    // Watchdog
    initial
    begin
        #8000000;
        errors++;
        end_sim();
    end
endmodule
